// >>> verilog/tgc_defs.vh
`ifndef TGC_DEFS_VH
`define TGC_DEFS_VH

// Register addresses
`define TGC_ADDR_IRQ_STATUS   8'h12
`define TGC_ADDR_IRQ_ENABLE   8'h15
`define TGC_ADDR_A_CTRL       8'h20
`define TGC_ADDR_B_CTRL       8'h21
`define TGC_ADDR_A_ACT_TIME   8'h24
`define TGC_ADDR_A_INA_TIME   8'h26
`define TGC_ADDR_B_ACT_TIME   8'h28
`define TGC_ADDR_B_INA_TIME   8'h2A
`define TGC_ADDR_FSK_DATA     8'h34
`define TGC_ADDR_FSK_ENHANCE  8'h6C
`define TGC_ADDR_A_FREQ       8'h00
`define TGC_ADDR_A_AMPL       8'h01
`define TGC_ADDR_A_PHASE      8'h02
`define TGC_ADDR_B_FREQ       8'h03
`define TGC_ADDR_B_AMPL       8'h04
`define TGC_ADDR_B_PHASE      8'h05
`define TGC_ADDR_MARK_FREQ    8'h45
`define TGC_ADDR_MARK_AMPL    8'h46
`define TGC_ADDR_MARK_PHASE   8'h47
`define TGC_ADDR_SPACE_FREQ   8'h48
`define TGC_ADDR_SPACE_AMPL   8'h49
`define TGC_ADDR_SPACE_PHASE  8'h4A

// Control, FSK enhance and FSK data register fields
`define TGC_CTRL_SEL_LSB      0
`define TGC_CTRL_SEL_MSB      1
`define TGC_CTRL_OSC_EN       2
`define TGC_CTRL_INA_EN       3
`define TGC_CTRL_ACT_EN       4
`define TGC_CTRL_ZC_EN        5
`define TGC_CTRL_RELOAD       6
`define TGC_CTRL_STATE        7
`define TGC_SEL_RX_BIT        0
`define TGC_SEL_TX_BIT        1
`define TGC_ENH_FSK_BIT       6
`define TGC_FSK_DATA_BIT      0

// Reset values
`define TGC_RST_CTRL          8'h00
`define TGC_RST_WORD          16'h0000
`define TGC_RST_BYTE          8'h00

// Timing
`define TGC_CLK_HZ            100000000
`define TGC_RATE_STD_HZ       16000
`define TGC_RATE_FSK_HZ       24000
`define TGC_TIMER_STEP_US     125
`define TGC_SAMPLES_PER_STEP  2

`endif

// >>> verilog/tgc_tone_gen.v
`timescale 1ns/100ps
`include "tgc_defs.vh"

module tgc_tone_gen #(
    parameter DIV_STD = `TGC_CLK_HZ / `TGC_RATE_STD_HZ,
    parameter DIV_FSK = `TGC_CLK_HZ / `TGC_RATE_FSK_HZ
) (
    input  wire        i_ref_clk,
    input  wire        i_rstn,
    input  wire [7:0]  i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [15:0] o_rdata,
    output reg  [15:0] o_rx_sample,
    output reg  [15:0] o_tx_sample,
    output reg         o_sample_valid
);

    // Samples per timer step (125 us at the standard rate), sized to the step counter
    localparam [1:0] STEP_N = `TGC_SAMPLES_PER_STEP;
    localparam       PH_ACT = 1'b0;
    localparam       PH_INA = 1'b1;

    // Saturate an 18-bit resonator state to a 16-bit sample
    function [15:0] sat16;
        input [17:0] v;
        begin
            if (!v[17] && (v[16:15] != 2'b00))
                sat16 = 16'h7FFF;
            else if (v[17] && (v[16:15] != 2'b11))
                sat16 = 16'h8000;
            else
                sat16 = v[15:0];
        end
    endfunction

    // Shared registers
    reg  [3:0]  irq_pend_reg;
    reg  [3:0]  irq_en_reg;
    reg  [7:0]  enhance_reg;
    reg         fsk_bit_reg;
    reg  [15:0] mark_freq_reg;
    reg  [15:0] mark_ampl_reg;
    reg  [15:0] mark_phase_reg;
    reg  [15:0] space_freq_reg;
    reg  [15:0] space_ampl_reg;
    reg  [15:0] space_phase_reg;

    // Per-generator views for readback and mixing
    wire [7:0]  ctrl_rd   [0:1];
    wire [15:0] act_rd    [0:1];
    wire [15:0] ina_rd    [0:1];
    wire [15:0] freq_rd   [0:1];
    wire [15:0] ampl_rd   [0:1];
    wire [15:0] phase_rd  [0:1];
    wire [15:0] smp       [0:1];
    wire [1:0]  route     [0:1];
    wire [1:0]  act_exp;
    wire [1:0]  ina_exp;
    wire [1:0]  smp_tick;

    // Enhanced FSK needs both the enhance bit and generator A reload bit
    wire enh_fsk = enhance_reg[`TGC_ENH_FSK_BIT] & ctrl_rd[0][`TGC_CTRL_RELOAD];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_tone
            localparam [7:0] A_CTRL  = g ? `TGC_ADDR_B_CTRL : `TGC_ADDR_A_CTRL;
            localparam [7:0] A_ACT   = g ? `TGC_ADDR_B_ACT_TIME : `TGC_ADDR_A_ACT_TIME;
            localparam [7:0] A_INA   = g ? `TGC_ADDR_B_INA_TIME : `TGC_ADDR_A_INA_TIME;
            localparam [7:0] A_FREQ  = g ? `TGC_ADDR_B_FREQ : `TGC_ADDR_A_FREQ;
            localparam [7:0] A_AMPL  = g ? `TGC_ADDR_B_AMPL : `TGC_ADDR_A_AMPL;
            localparam [7:0] A_PHASE = g ? `TGC_ADDR_B_PHASE : `TGC_ADDR_A_PHASE;

            reg  [1:0]  sel_reg;
            reg         osc_en_reg;
            reg         ina_en_reg;
            reg         act_en_reg;
            reg         zc_en_reg;
            reg         reload_reg;
            reg  [15:0] act_time_reg;
            reg  [15:0] ina_time_reg;
            reg  [15:0] freq_reg;
            reg  [15:0] ampl_reg;
            reg  [15:0] phase_reg;
            reg  [15:0] run_freq_reg;
            reg  [17:0] y1_reg;
            reg  [17:0] y2_reg;
            reg         run_reg;
            reg         phase_st_reg;
            reg  [15:0] cnt_reg;
            reg  [12:0] div_reg;
            reg  [1:0]  step_reg;
            reg         act_exp_reg;
            reg         ina_exp_reg;

            wire        fast   = (g == 0) && enh_fsk;
            wire [12:0] div_n  = fast ? DIV_FSK[12:0] : DIV_STD[12:0];
            // Compare with >= so that a switch to the shorter divide, made while
            // the count already lies past the new end, ends the period at once
            // instead of running the counter through its whole range
            wire        tick   = (div_reg >= div_n - 13'd1);
            wire        step   = tick && (step_reg == STEP_N - 2'd1);
            wire        cad_on = act_en_reg && ina_en_reg;
            wire        wr_ctl = i_wr && (i_addr == A_CTRL);
            // Compare one step ahead, so a count of N expires on step N
            wire [16:0] cnt_p1 = {1'b0, cnt_reg} + 17'd1;
            wire        act_hit = (cnt_p1 >= {1'b0, act_time_reg});
            wire        ina_hit = (cnt_p1 >= {1'b0, ina_time_reg});
            wire        do_act = step && act_en_reg && (phase_st_reg == PH_ACT) && osc_en_reg;
            wire        do_ina = step && cad_on && (phase_st_reg == PH_INA);

            // Resonator arithmetic: 2*c*y1/2^15 - y2
            wire signed [33:0] prod  = $signed(run_freq_reg) * $signed(y1_reg);
            wire signed [17:0] y_new = prod[31:14] - $signed(y2_reg);
            // A sign change from the last sample marks a zero crossing
            wire        zero_x = (y_new[17] != y1_reg[17]);

            // Sample-rate divider and timer step counter
            always @(posedge i_ref_clk) begin
                if (!i_rstn) begin
                    div_reg  <= 13'h0000;
                    step_reg <= 2'h0;
                end else if (tick) begin
                    div_reg  <= 13'h0000;
                    step_reg <= (step_reg == STEP_N - 2'd1) ? 2'h0 : step_reg + 2'd1;
                end else begin
                    div_reg  <= div_reg + 13'd1;
                end
            end

            // Control and coefficient registers; timers may drive the enable bit
            always @(posedge i_ref_clk) begin
                if (!i_rstn) begin
                    sel_reg      <= 2'h0;
                    osc_en_reg   <= 1'b0;
                    ina_en_reg   <= 1'b0;
                    act_en_reg   <= 1'b0;
                    zc_en_reg    <= 1'b0;
                    reload_reg   <= 1'b0;
                    act_time_reg <= `TGC_RST_WORD;
                    ina_time_reg <= `TGC_RST_WORD;
                    freq_reg     <= `TGC_RST_WORD;
                    ampl_reg     <= `TGC_RST_WORD;
                    phase_reg    <= `TGC_RST_WORD;
                end else begin
                    if (do_act && act_hit)
                        osc_en_reg <= 1'b0;
                    else if (do_ina && ina_hit)
                        osc_en_reg <= 1'b1;
                    if (wr_ctl) begin
                        sel_reg    <= i_wdata[`TGC_CTRL_SEL_MSB:`TGC_CTRL_SEL_LSB];
                        osc_en_reg <= i_wdata[`TGC_CTRL_OSC_EN];
                        ina_en_reg <= i_wdata[`TGC_CTRL_INA_EN];
                        act_en_reg <= i_wdata[`TGC_CTRL_ACT_EN];
                        zc_en_reg  <= i_wdata[`TGC_CTRL_ZC_EN];
                        reload_reg <= (g == 0) ? i_wdata[`TGC_CTRL_RELOAD] : 1'b0;
                    end
                    if (i_wr && i_addr == A_ACT)
                        act_time_reg <= i_wdata;
                    if (i_wr && i_addr == A_INA)
                        ina_time_reg <= i_wdata;
                    if (i_wr && i_addr == A_FREQ)
                        freq_reg <= i_wdata;
                    if (i_wr && i_addr == A_AMPL)
                        ampl_reg <= i_wdata;
                    if (i_wr && i_addr == A_PHASE)
                        phase_reg <= i_wdata;
                end
            end

            // Shared cadence counter: active run, clear, inactive run, repeat
            always @(posedge i_ref_clk) begin
                if (!i_rstn) begin
                    cnt_reg      <= 16'h0000;
                    phase_st_reg <= PH_ACT;
                    act_exp_reg  <= 1'b0;
                    ina_exp_reg  <= 1'b0;
                end else begin
                    act_exp_reg <= do_act && act_hit;
                    ina_exp_reg <= do_ina && ina_hit;
                    if (!act_en_reg) begin
                        cnt_reg      <= 16'h0000;
                        phase_st_reg <= PH_ACT;
                    end else if (do_act) begin
                        if (act_hit) begin
                            cnt_reg      <= 16'h0000;
                            phase_st_reg <= ina_en_reg ? PH_INA : PH_ACT;
                        end else begin
                            cnt_reg <= cnt_p1[15:0];
                        end
                    end else if (do_ina) begin
                        if (ina_hit) begin
                            cnt_reg      <= 16'h0000;
                            phase_st_reg <= PH_ACT;
                        end else begin
                            cnt_reg <= cnt_p1[15:0];
                        end
                    end
                end
            end

            // Resonator: seeded on start, ends at zero crossing when asked
            always @(posedge i_ref_clk) begin
                if (!i_rstn) begin
                    run_reg      <= 1'b0;
                    y1_reg       <= 18'h00000;
                    y2_reg       <= 18'h00000;
                    run_freq_reg <= `TGC_RST_WORD;
                end else begin
                    if (act_exp_reg && reload_reg && run_reg) begin
                        if (fast)
                            run_freq_reg <= fsk_bit_reg ? mark_freq_reg : space_freq_reg;
                        else
                            run_freq_reg <= freq_reg;
                    end
                    if (tick) begin
                        if (osc_en_reg && !run_reg) begin
                            run_reg      <= 1'b1;
                            run_freq_reg <= freq_reg;
                            y1_reg       <= {{2{ampl_reg[15]}}, ampl_reg};
                            y2_reg       <= {{2{phase_reg[15]}}, phase_reg};
                        end else if (run_reg) begin
                            if (!osc_en_reg && (!zc_en_reg || zero_x)) begin
                                run_reg <= 1'b0;
                                y1_reg  <= 18'h00000;
                                y2_reg  <= 18'h00000;
                            end else begin
                                y1_reg <= y_new;
                                y2_reg <= y1_reg;
                            end
                        end
                    end
                end
            end

            assign ctrl_rd[g]  = {run_reg, reload_reg, zc_en_reg, act_en_reg,
                                  ina_en_reg, osc_en_reg, sel_reg};
            assign act_rd[g]   = act_time_reg;
            assign ina_rd[g]   = ina_time_reg;
            assign freq_rd[g]  = freq_reg;
            assign ampl_rd[g]  = ampl_reg;
            assign phase_rd[g] = phase_reg;
            assign smp[g]      = run_reg ? sat16(y1_reg) : 16'h0000;
            assign route[g]    = sel_reg;
            assign act_exp[g]  = act_exp_reg;
            assign ina_exp[g]  = ina_exp_reg;
            assign smp_tick[g] = tick;
        end
    endgenerate

    // Enhanced FSK: generator A reloads its frequency from mark or space, chosen by the last written bit
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            enhance_reg     <= `TGC_RST_BYTE;
            fsk_bit_reg     <= 1'b0;
            irq_en_reg      <= 4'h0;
            mark_freq_reg   <= `TGC_RST_WORD;
            mark_ampl_reg   <= `TGC_RST_WORD;
            mark_phase_reg  <= `TGC_RST_WORD;
            space_freq_reg  <= `TGC_RST_WORD;
            space_ampl_reg  <= `TGC_RST_WORD;
            space_phase_reg <= `TGC_RST_WORD;
        end else if (i_wr) begin
            if (i_addr == `TGC_ADDR_FSK_ENHANCE)
                enhance_reg <= i_wdata[7:0];
            else if (i_addr == `TGC_ADDR_FSK_DATA)
                fsk_bit_reg <= i_wdata[`TGC_FSK_DATA_BIT];
            else if (i_addr == `TGC_ADDR_IRQ_ENABLE)
                irq_en_reg <= i_wdata[3:0];
            else if (i_addr == `TGC_ADDR_MARK_FREQ)
                mark_freq_reg <= i_wdata;
            else if (i_addr == `TGC_ADDR_MARK_AMPL)
                mark_ampl_reg <= i_wdata;
            else if (i_addr == `TGC_ADDR_MARK_PHASE)
                mark_phase_reg <= i_wdata;
            else if (i_addr == `TGC_ADDR_SPACE_FREQ)
                space_freq_reg <= i_wdata;
            else if (i_addr == `TGC_ADDR_SPACE_AMPL)
                space_ampl_reg <= i_wdata;
            else if (i_addr == `TGC_ADDR_SPACE_PHASE)
                space_phase_reg <= i_wdata;
        end
    end

    // Pending bits: write one to clear, a new expiry wins over the clear
    wire [3:0] pend_set = {ina_exp[1], act_exp[1], ina_exp[0], act_exp[0]};
    // Clear mask from a write to the status register
    wire [3:0] pend_clr = (i_wr && i_addr == `TGC_ADDR_IRQ_STATUS) ? i_wdata[3:0] : 4'h0;

    always @(posedge i_ref_clk) begin
        if (!i_rstn)
            irq_pend_reg <= 4'h0;
        else
            irq_pend_reg <= (irq_pend_reg & ~pend_clr) | pend_set;
    end

    // Read data for the cycle after the strobe, zero otherwise
    always @(posedge i_ref_clk) begin
        if (!i_rstn)
            o_rdata <= 16'h0000;
        else if (!i_rd)
            o_rdata <= 16'h0000;
        else if (i_addr == `TGC_ADDR_IRQ_STATUS)
            o_rdata <= {12'h000, irq_pend_reg};
        else if (i_addr == `TGC_ADDR_IRQ_ENABLE)
            o_rdata <= {12'h000, irq_en_reg};
        else if (i_addr == `TGC_ADDR_A_CTRL)
            o_rdata <= {8'h00, ctrl_rd[0]};
        else if (i_addr == `TGC_ADDR_B_CTRL)
            o_rdata <= {8'h00, ctrl_rd[1]};
        else if (i_addr == `TGC_ADDR_A_ACT_TIME)
            o_rdata <= act_rd[0];
        else if (i_addr == `TGC_ADDR_A_INA_TIME)
            o_rdata <= ina_rd[0];
        else if (i_addr == `TGC_ADDR_B_ACT_TIME)
            o_rdata <= act_rd[1];
        else if (i_addr == `TGC_ADDR_B_INA_TIME)
            o_rdata <= ina_rd[1];
        else if (i_addr == `TGC_ADDR_FSK_DATA)
            o_rdata <= {15'h0000, fsk_bit_reg};
        else if (i_addr == `TGC_ADDR_FSK_ENHANCE)
            o_rdata <= {8'h00, enhance_reg};
        else if (i_addr == `TGC_ADDR_A_FREQ)
            o_rdata <= freq_rd[0];
        else if (i_addr == `TGC_ADDR_A_AMPL)
            o_rdata <= ampl_rd[0];
        else if (i_addr == `TGC_ADDR_A_PHASE)
            o_rdata <= phase_rd[0];
        else if (i_addr == `TGC_ADDR_B_FREQ)
            o_rdata <= freq_rd[1];
        else if (i_addr == `TGC_ADDR_B_AMPL)
            o_rdata <= ampl_rd[1];
        else if (i_addr == `TGC_ADDR_B_PHASE)
            o_rdata <= phase_rd[1];
        else if (i_addr == `TGC_ADDR_MARK_FREQ)
            o_rdata <= mark_freq_reg;
        else if (i_addr == `TGC_ADDR_MARK_AMPL)
            o_rdata <= mark_ampl_reg;
        else if (i_addr == `TGC_ADDR_MARK_PHASE)
            o_rdata <= mark_phase_reg;
        else if (i_addr == `TGC_ADDR_SPACE_FREQ)
            o_rdata <= space_freq_reg;
        else if (i_addr == `TGC_ADDR_SPACE_AMPL)
            o_rdata <= space_ampl_reg;
        else if (i_addr == `TGC_ADDR_SPACE_PHASE)
            o_rdata <= space_phase_reg;
        else
            o_rdata <= 16'h0000;
    end

    // Route and mix the two tones onto the audio paths
    wire [15:0] rx_a = route[0][`TGC_SEL_RX_BIT] ? smp[0] : 16'h0000;
    wire [15:0] rx_b = route[1][`TGC_SEL_RX_BIT] ? smp[1] : 16'h0000;
    wire [15:0] tx_a = route[0][`TGC_SEL_TX_BIT] ? smp[0] : 16'h0000;
    wire [15:0] tx_b = route[1][`TGC_SEL_TX_BIT] ? smp[1] : 16'h0000;
    wire [17:0] rx_sum = {{2{rx_a[15]}}, rx_a} + {{2{rx_b[15]}}, rx_b};
    wire [17:0] tx_sum = {{2{tx_a[15]}}, tx_a} + {{2{tx_b[15]}}, tx_b};

    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_rx_sample    <= 16'h0000;
            o_tx_sample    <= 16'h0000;
            o_sample_valid <= 1'b0;
        end else begin
            o_rx_sample    <= sat16(rx_sum);
            o_tx_sample    <= sat16(tx_sum);
            o_sample_valid <= |smp_tick;
        end
    end

endmodule

// >>> tb/tgc_tone_gen_props.sv
`timescale 1ns/100ps
// Port-level checks on register reads and the sample stream
module tgc_tone_gen_props #(
    parameter DIV_STD = 8,
    parameter DIV_FSK = 6
) (
    input wire        i_ref_clk,
    input wire        i_rstn,
    input wire [7:0]  i_addr,
    input wire [15:0] i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire [15:0] o_rdata,
    input wire [15:0] o_rx_sample,
    input wire [15:0] o_tx_sample,
    input wire        o_sample_valid
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // Register read side
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not idle");
    unmapped_zero_a: assert property ($past(i_rd) && $past(i_addr) == 8'h7F
        |-> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    b_no_reload_a: assert property ($past(i_rd) && $past(i_addr) == 8'h21
        |-> !o_rdata[6])
        else $error("reload bit seen on second generator");
    ctrl_upper_a: assert property ($past(i_rd) && $past(i_addr) == 8'h20
        |-> o_rdata[15:8] == 8'h00)
        else $error("control upper bits set");
    status_upper_a: assert property ($past(i_rd) && $past(i_addr) == 8'h12
        |-> o_rdata[15:4] == 12'h000)
        else $error("status upper bits set");
    irq_en_upper_a: assert property ($past(i_rd) && $past(i_addr) == 8'h15
        |-> o_rdata[15:4] == 12'h000)
        else $error("enable upper bits set");
    coef_readback_a: assert property ($past(i_wr, 2) && $past(i_rd)
        && $past(i_addr) == $past(i_addr, 2)
        && $past(i_addr) < 8'h06 |-> o_rdata == $past(i_wdata, 2))
        else $error("coefficient readback differs");
    // Receive samples move only right after a sample step
    sample_hold_a: assert property ($changed(o_rx_sample) |-> $past(o_sample_valid)
        || $past(o_sample_valid, 2))
        else $error("sample changed between steps");
    cov_valid_c: cover property (o_sample_valid);
    cov_pend_c: cover property ($past(i_rd) && $past(i_addr) == 8'h12 && o_rdata[3:0] != 4'h0);
    cov_tx_c: cover property (o_tx_sample != 16'h0000);
endmodule

bind tgc_tone_gen tgc_tone_gen_props #(.DIV_STD(DIV_STD), .DIV_FSK(DIV_FSK)) props_inst (
    .i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_rx_sample, .o_tx_sample, .o_sample_valid);

// >>> tb/tgc_audio_sink.sv
`timescale 1ns/100ps
// Receive audio path stand-in: counts sample steps, logs first settled samples
module tgc_audio_sink (
    input wire        i_ref_clk,
    input wire        i_clr,
    input wire        i_valid,
    input wire [15:0] i_rx,
    output int        o_steps
);
    logic [15:0] rx_log [0:7];
    logic        valid_d = 1'b0;
    initial o_steps = 0;
    // Sample settles one cycle after its step pulse
    always @(posedge i_ref_clk) begin
        valid_d <= i_valid;
        if (i_clr)
            o_steps <= 0;
        else if (i_valid)
            o_steps <= o_steps + 1;
        if (valid_d && o_steps > 0 && o_steps < 9)
            rx_log[o_steps-1] <= i_rx;
    end
endmodule

// >>> tb/tb_tgc_tone_gen.sv
`timescale 1ns/100ps
module tb_tgc_tone_gen;
    logic i_ref_clk, i_rstn, i_wr, i_rd, clr;
    logic [7:0] i_addr;
    logic [15:0] i_wdata, o_rdata, o_rx_sample, o_tx_sample, d, e0, e1;
    logic o_sample_valid;
    int steps, miscompares = 0, checks_done = 0, k, y0, y1;
    logic [7:0] regs [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h24,
                              8'h26, 8'h28, 8'h2A, 8'h12, 8'h15, 8'h20, 8'h21};
    tgc_tone_gen #(.DIV_STD(8), .DIV_FSK(6)) tgc_tone_gen_inst (.i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_rx_sample(o_rx_sample), .o_tx_sample(o_tx_sample),
        .o_sample_valid(o_sample_valid));
    tgc_audio_sink tgc_audio_sink_inst (.i_ref_clk(i_ref_clk), .i_clr(clr),
        .i_valid(o_sample_valid), .i_rx(o_rx_sample), .o_steps(steps));
    // 100 MHz clock
    initial begin
        i_ref_clk = 0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1;
        @(posedge i_ref_clk);
        i_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1;
        @(posedge i_ref_clk);
        i_rd <= 0;
        #1 q = o_rdata;
    endtask
    // Write then read the same place with no gap
    task automatic wrrd(input logic [7:0] a, input logic [15:0] v, output logic [15:0] q);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1;
        @(posedge i_ref_clk);
        i_wr <= 0;
        i_rd <= 1;
        @(posedge i_ref_clk);
        i_rd <= 0;
        #1 q = o_rdata;
    endtask
    task automatic wait_pend(input int b);
        logic [15:0] s;
        for (int n = 0; n < 300; n++) begin
            rd(8'h12, s);
            if (s[b] === 1'b1) begin
                chk(s[b], 1'b1);
                return;
            end
        end
        miscompares++;
        $display("Error at %0t: pending bit %0d never set", $time, b);
        tally_and_finish();
    endtask
    task automatic tally_and_finish;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        i_rstn = 0; i_addr = 0; i_wdata = 0; i_wr = 0; i_rd = 0; clr = 0;
        repeat (3) @(posedge i_ref_clk);
        i_rstn <= 1;
        foreach (regs[k]) begin
            rd(regs[k], d);
            chk(d, 16'h0000);
        end
        for (k = 0; k < 10; k++) begin
            wrrd(regs[k], 16'hA5C0 + k, d);
            chk(d, 16'hA5C0 + k);
        end
        wrrd(8'h15, 16'hFFFF, d);
        chk(d, 16'h000F);
        wrrd(8'h21, 16'h0040, d);
        chk(d, 16'h0000);
        wrrd(8'h20, 16'h0040, d);
        chk(d, 16'h0040);
        wrrd(8'h34, 16'h0001, d);
        chk(d, 16'h0001);
        wrrd(8'h7F, 16'hFFFF, d);
        chk(d, 16'h0000);
        // Generator A control and interrupt enables cleared first, then coefficients, then timers, then pending bits
        wr(8'h20, 16'h0000);
        wr(8'h15, 16'h0000);
        wr(8'h00, 16'h78E6);
        wr(8'h01, 16'h02B3);
        wr(8'h02, 16'h0000);
        wr(8'h03, 16'h6EC9);
        wr(8'h04, 16'h044B);
        wr(8'h05, 16'h0000);
        wr(8'h24, 16'h0001);
        wr(8'h26, 16'h0002);
        wr(8'h28, 16'h0002);
        wr(8'h12, 16'h000F);
        // Direct control on generator A to receive
        clr <= 1;
        wr(8'h20, 16'h0005);
        clr <= 0;
        repeat (240) @(posedge i_ref_clk);
        #1;
        chk(steps >= 29 && steps <= 32, 1'b1);
        for (k = 0; k < 5 && tgc_audio_sink_inst.rx_log[k] == 16'h0000; k++);
        y0 = 691;
        y1 = ((2 * 30950 * y0) >>> 15) - 0;
        e0 = y1;
        e1 = ((2 * 30950 * y1) >>> 15) - y0;
        chk(tgc_audio_sink_inst.rx_log[k], 16'h02B3);
        chk(tgc_audio_sink_inst.rx_log[k+1], e0);
        chk(tgc_audio_sink_inst.rx_log[k+2], e1);
        chk(o_tx_sample, 16'h0000);
        rd(8'h20, d);
        chk(d & 16'h0080, 16'h0080);
        wr(8'h20, 16'h0001);
        repeat (40) @(posedge i_ref_clk);
        rd(8'h20, d);
        chk(d & 16'h0084, 16'h0000);
        // One-shot burst on generator B to transmit
        wr(8'h21, 16'h0016);
        repeat (20) @(posedge i_ref_clk);
        #1;
        chk(o_tx_sample !== 16'h0000, 1'b1);
        wait_pend(2);
        repeat (60) @(posedge i_ref_clk);
        rd(8'h21, d);
        chk(d & 16'h0084, 16'h0000);
        rd(8'h12, d);
        chk(d & 16'h0004, 16'h0004);
        wrrd(8'h12, 16'h0004, d);
        chk(d & 16'h0004, 16'h0000);
        // Automatic cadence with zero-cross on generator A
        wr(8'h20, 16'h003D);
        wait_pend(0);
        // Burst outlives its active step while waiting for the zero crossing
        repeat (24) @(posedge i_ref_clk);
        rd(8'h20, d);
        chk(d & 16'h0080, 16'h0080);
        wr(8'h12, 16'h0001);
        wait_pend(1);
        wr(8'h12, 16'h0002);
        wait_pend(0);
        wr(8'h20, 16'h0001);
        wr(8'h12, 16'h000F);
        repeat (200) @(posedge i_ref_clk);
        rd(8'h12, d);
        chk(d & 16'h0003, 16'h0000);
        // Enhanced FSK steps generator A faster
        wrrd(8'h6C, 16'h0040, d);
        chk(d, 16'h0040);
        clr <= 1;
        wr(8'h20, 16'h0045);
        clr <= 0;
        repeat (240) @(posedge i_ref_clk);
        #1;
        chk(steps >= 38, 1'b1);
        tally_and_finish();
    end
endmodule
